// *** verilog/mbst_ctrl.v ***
// Buffer memory self-test controller: registers, fill engine, port swap.
// Assumes the copy engine, its checksum and the memory live outside.
// Operation
// - Fill whole 8-Kbyte buffer, load checksum at end
// - Selection field picks one of four patterns
// - Swap bit exchanges memory ports of engines
// - Start bit runs test, self-clears when done
// - Clearing start, copy start, enable aborts
// - Copy read-back paced one byte per cycle
// - One byte written per clock cycle
// - Seed used directly or as LFSR seed
// - Random fill from LFSR, seed register updated
// - Race mode starts copy engine automatically
// - Address fill writes address low byte
// - Pattern shift rotates seed left each location
`timescale 1ns/10ps
`include "mbst_consts.vh"

module mbst_ctrl (
   // Clock and reset
   input wire clk_sys,
   input wire srst,
   // Register writes
   input wire ctl_wr,
   input wire [7:0] ctl_wdata,
   input wire seed_wr,
   input wire [7:0] seed_wdata,
   // Register reads
   output wire [7:0] self_test_control,
   output wire [7:0] fill_seed,
   output wire [7:0] fill_checksum_high,
   output wire [7:0] fill_checksum_low,
   // Copy engine handshake
   input wire copy_engine_start,
   output wire copy_start_set,
   // Memory port A (self-test writer unless swapped)
   output wire porta_we,
   output wire [12:0] porta_addr,
   output wire [7:0] porta_wdata,
   // Memory port B (copy reader unless swapped)
   output wire portb_we,
   output wire [12:0] portb_addr,
   output wire [7:0] portb_wdata,
   // Copy reader request, routed to its port
   input wire copy_rd_en,
   input wire [12:0] copy_rd_addr,
   output wire copy_rd_pace
);

   localparam ST_IDLE = 1'b0;
   localparam ST_FILL = 1'b1;

   reg [7:0] ctl_r;
   reg [7:0] seed_r;
   reg [7:0] seed_nxt;
   reg [15:0] csum_r;
   reg state_r;
   reg [12:0] addr_r;
   reg race_r;
   wire [15:0] sum_run;
   wire [15:0] sum_fin;
   wire [1:0] sel;
   wire [2:0] psv;
   wire swap;
   wire wr_en;
   reg [7:0] wr_dat;
   wire start_req;
   wire abort;
   wire last;

   function [7:0] rotl8;
      input [7:0] v;
      input [2:0] n;
      reg [15:0] d;
      begin
         d = {v, v} << n;
         rotl8 = d[15:8];
      end
   endfunction

   function [7:0] lfsr8;
      input [7:0] v;
      begin
         lfsr8 = {v[6:0], ^(v & `MBST_LFSR_TAPS)};
      end
   endfunction

   assign sel = ctl_r[`MBST_CTL_SEL_MSB:`MBST_CTL_SEL_LSB];
   assign psv = ctl_r[`MBST_CTL_PSV_MSB:`MBST_CTL_PSV_LSB];
   assign swap = ctl_r[`MBST_CTL_SWAP_BIT];
   assign wr_en = (state_r == ST_FILL);
   assign last = (addr_r == `MBST_LAST_ADDR);
   assign start_req = ctl_wr && ctl_wdata[`MBST_CTL_START_BIT] && (state_r == ST_IDLE);
   assign abort = ctl_wr && !ctl_wdata[`MBST_CTL_START_BIT]
      && !ctl_wdata[`MBST_CTL_TME_BIT] && !copy_engine_start;

   // ----------------------------------------
   // Pattern source
   // ----------------------------------------
   always @* begin
      seed_nxt = seed_r;
      case (sel)
         `MBST_SEL_ADDRESS: begin
            wr_dat = addr_r[7:0];
         end
         `MBST_SEL_SHIFT: begin
            wr_dat = seed_r;
            seed_nxt = rotl8(seed_r, psv);
         end
         default: begin
            // Random and race; zero seed stays zero
            wr_dat = seed_r;
            seed_nxt = lfsr8(seed_r);
         end
      endcase
   end

   // ----------------------------------------
   // Control and fill engine
   // ----------------------------------------
   always @(posedge clk_sys) begin
      if (srst) begin
         ctl_r <= `MBST_CTL_RESET;
         seed_r <= `MBST_SEED_RESET;
         csum_r <= `MBST_CSUM_RESET;
         state_r <= ST_IDLE;
         addr_r <= 13'h0000;
         race_r <= 1'b0;
      end else begin
         race_r <= 1'b0;
         if (ctl_wr) begin
            ctl_r <= ctl_wdata;
         end
         if (seed_wr && state_r == ST_IDLE) begin
            seed_r <= seed_wdata;
         end
         case (state_r)
            ST_IDLE: begin
               if (start_req) begin
                  state_r <= ST_FILL;
                  addr_r <= 13'h0000;
                  race_r <= (ctl_wdata[`MBST_CTL_SEL_MSB:`MBST_CTL_SEL_LSB]
                     == `MBST_SEL_RACE);
               end
            end
            ST_FILL: begin
               if (abort) begin
                  state_r <= ST_IDLE;
               end else begin
                  addr_r <= addr_r + 13'h0001;
                  seed_r <= seed_nxt;
                  if (last) begin
                     state_r <= ST_IDLE;
                     csum_r <= ~sum_fin;
                     ctl_r[`MBST_CTL_START_BIT] <= 1'b0;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   mbst_csum u_csum (
      .clk_sys(clk_sys),
      .srst(srst),
      .clr(start_req),
      .byte_vld(wr_en),
      .byte_dat(wr_dat),
      .odd_pos(addr_r[0]),
      .sum_r(sum_run)
   );

   // Last byte is odd, so its pair closes here
   assign sum_fin = sum_run + {8'h00, wr_dat} + {15'h0000,
      ((({1'b0, sum_run} + {9'h000, wr_dat}) >> 16) != 17'h00000)};

   // ----------------------------------------
   // Port swap and outputs
   // ----------------------------------------
   assign porta_we = swap ? 1'b0 : wr_en;
   assign porta_addr = swap ? copy_rd_addr : addr_r;
   assign porta_wdata = swap ? 8'h00 : wr_dat;
   assign portb_we = swap ? wr_en : 1'b0;
   assign portb_addr = swap ? addr_r : copy_rd_addr;
   assign portb_wdata = swap ? wr_dat : 8'h00;
   // While a fill runs, reader may take a byte only behind the writer
   assign copy_rd_pace = copy_rd_en && (!wr_en || copy_rd_addr < addr_r);
   assign copy_start_set = race_r;
   assign self_test_control = ctl_r;
   assign fill_seed = seed_r;
   assign fill_checksum_high = csum_r[15:8];
   assign fill_checksum_low = csum_r[7:0];

endmodule // mbst_ctrl

// *** verilog/mbst_consts.vh ***
// Constants for the buffer memory self-test controller.
// Assumes inclusion by bare name from the design files.
`ifndef MBST_CONSTS_VH
`define MBST_CONSTS_VH

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define MBST_CTL_START_BIT 0
`define MBST_CTL_TME_BIT 1
`define MBST_CTL_SEL_LSB 2
`define MBST_CTL_SEL_MSB 3
`define MBST_CTL_SWAP_BIT 4
`define MBST_CTL_PSV_LSB 5
`define MBST_CTL_PSV_MSB 7
`define MBST_CTL_RESET 8'h00
`define MBST_SEED_RESET 8'h00
`define MBST_CSUM_RESET 16'h0000

// ----------------------------------------
// Test selections
// ----------------------------------------
`define MBST_SEL_RANDOM 2'h0
`define MBST_SEL_ADDRESS 2'h1
`define MBST_SEL_SHIFT 2'h2
`define MBST_SEL_RACE 2'h3

// ----------------------------------------
// Buffer geometry and LFSR
// ----------------------------------------
`define MBST_ADDR_W 13
`define MBST_LAST_ADDR 13'h1FFF
`define MBST_LFSR_TAPS 8'hB8

`endif

// *** verilog/mbst_csum.v ***
// One's-complement 16-bit checksum accumulator, big-endian byte pairing.
// Assumes one byte offered per cycle with byte_vld, cleared by clr.
`timescale 1ns/10ps
`include "mbst_consts.vh"

module mbst_csum (
   // Clock and reset
   input wire clk_sys,
   input wire srst,
   // Byte stream
   input wire clr,
   input wire byte_vld,
   input wire [7:0] byte_dat,
   input wire odd_pos,
   // Running sum, not yet complemented
   output reg [15:0] sum_r
);

   function [15:0] oc_add;
      input [15:0] a;
      input [15:0] b;
      reg [16:0] s;
      begin
         s = {1'b0, a} + {1'b0, b};
         oc_add = s[15:0] + {15'h0000, s[16]};
      end
   endfunction

   always @(posedge clk_sys) begin
      if (srst || clr) begin
         sum_r <= `MBST_CSUM_RESET;
      end else if (byte_vld) begin
         // Even address is the high byte of each pair
         sum_r <= oc_add(sum_r, odd_pos ? {8'h00, byte_dat} : {byte_dat, 8'h00});
      end
   end

endmodule // mbst_csum

// *** tb/mbst_copy_model.sv ***
// Copy engine stand-in: paced read-back over the whole buffer, no checksum.
// Assumes the controller paces reads through copy_rd_pace.
`timescale 1ns/10ps
module mbst_copy_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Start requests and read pacing
   input wire logic go,
   input wire logic copy_start_set,
   input wire logic copy_rd_pace,
   // Reader side
   output logic copy_engine_start,
   output logic copy_rd_en,
   output logic [12:0] copy_rd_addr
);
   assign copy_rd_en = copy_engine_start;
   always @(posedge clk_sys) begin
      if (srst) begin
         copy_engine_start <= 1'b0;
         copy_rd_addr <= 13'h0000;
      end else if (!copy_engine_start) begin
         copy_engine_start <= go | copy_start_set;
         copy_rd_addr <= 13'h0000;
      end else if (copy_rd_pace) begin
         copy_rd_addr <= copy_rd_addr + 13'h0001;
         if (copy_rd_addr == 13'h1FFF) copy_engine_start <= 1'b0;
      end
   end
endmodule // mbst_copy_model

// *** tb/mbst_monitor.sv ***
// Port checker for the self-test controller.
// Assumes binding onto mbst_ctrl.
`timescale 1ns/10ps
module mbst_monitor (
   input wire clk_sys,
   input wire srst,
   input wire ctl_wr,
   input wire [7:0] ctl_wdata,
   input wire [7:0] self_test_control,
   input wire copy_engine_start,
   input wire copy_start_set,
   input wire porta_we,
   input wire [12:0] porta_addr,
   input wire [7:0] porta_wdata,
   input wire portb_we
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   wire go = ctl_wr && ctl_wdata[0] && !self_test_control[0];
   wire [15:0] rot = {porta_wdata, porta_wdata} << self_test_control[7:5];
   start_busy_a: assert property (go |=> self_test_control[0] && porta_addr == 13'h0000)
      else $error("start not taken");
   byte_rate_a: assert property (porta_we && $past(porta_we) |->
      porta_addr == $past(porta_addr) + 13'h0001) else $error("fill rate wrong");
   swap_write_a: assert property (self_test_control[4] |-> !porta_we)
      else $error("writer on port A while swapped");
   normal_write_a: assert property (!self_test_control[4] |-> !portb_we)
      else $error("writer on port B unswapped");
   race_start_a: assert property (go && ctl_wdata[3:2] == 2'h3 |=> copy_start_set)
      else $error("race start missing");
   race_only_a: assert property (copy_start_set |-> self_test_control[3:2] == 2'h3)
      else $error("copy start outside race");
   addr_data_a: assert property (porta_we && self_test_control[3:2] == 2'h1 |->
      porta_wdata == porta_addr[7:0]) else $error("address fill data");
   shift_rot_a: assert property (porta_we && self_test_control[3:2] == 2'h2 ##1 porta_we
      |-> porta_wdata == $past(rot[15:8])) else $error("rotate wrong");
   abort_a: assert property (ctl_wr && ctl_wdata[1:0] == 2'h0 && !copy_engine_start
      |=> !self_test_control[0] ##1 !porta_we) else $error("abort ignored");
   cov_race_c: cover property (copy_start_set);
   cov_swap_c: cover property (portb_we);
   cov_shift_c: cover property (porta_we && self_test_control[3:2] == 2'h2);
endmodule // mbst_monitor
bind mbst_ctrl mbst_monitor i_mbst_monitor (.clk_sys, .srst, .ctl_wr, .ctl_wdata,
   .self_test_control, .copy_engine_start, .copy_start_set, .porta_we, .porta_addr,
   .porta_wdata, .portb_we);

// *** tb/mbst_ctrl_tb_top.sv ***
// Self-checking bench for the self-test controller.
// Assumes the copy engine model answers reads at once.
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("FAIL %0t got %h exp %h", $time, a, b); end end
module mbst_ctrl_tb_top;
   logic clk_sys = 0, srst = 1, ctl_wr = 0, seed_wr = 0, go = 0;
   logic [7:0] ctl_wdata = 0, seed_wdata = 0, stc, fsd, csh, csl;
   logic ces, css, rd_en, pace;
   logic [23:0] ef;
   logic [12:0] rd_addr;
   int miscompares = 0, n_checks = 0, cyc = 0;
   logic [31:0] rs = 75572;
   logic [7:0] sd;
   always #4 clk_sys = ~clk_sys;
   mbst_ctrl i_mbst_ctrl (.clk_sys, .srst, .ctl_wr, .ctl_wdata, .seed_wr, .seed_wdata,
      .self_test_control(stc), .fill_seed(fsd), .fill_checksum_high(csh),
      .fill_checksum_low(csl), .copy_engine_start(ces), .copy_start_set(css),
      .porta_we(), .porta_addr(), .porta_wdata(), .portb_we(), .portb_addr(),
      .portb_wdata(), .copy_rd_en(rd_en), .copy_rd_addr(rd_addr), .copy_rd_pace(pace));
   mbst_copy_model i_mbst_copy_model (.clk_sys, .srst, .go, .copy_start_set(css),
      .copy_rd_pace(pace),
      .copy_engine_start(ces), .copy_rd_en(rd_en), .copy_rd_addr(rd_addr));
   function automatic [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Zero seed and address fill are closed forms; others summed here
   // Returns final seed and checksum; rnd picks the LFSR step over rotate
   function automatic [23:0] exp_fill(input [7:0] v, input [2:0] n, input bit rnd);
      logic [16:0] s;
      logic [15:0] t;
      s = 0;
      for (int i = 0; i < 8192; i++) begin
         s = s[15:0] + (i[0] ? {8'h00, v} : {v, 8'h00});
         s = s[15:0] + s[16];
         t = {v, v} << n;
         v = rnd ? {v[6:0], ^(v & 8'hB8)} : t[15:8];
      end
      exp_fill = {v, ~s[15:0]};
   endfunction
   task automatic wr(input bit s, input [7:0] v);
      @(posedge clk_sys);
      if (s) begin seed_wr <= 1; seed_wdata <= v; end
      else begin ctl_wr <= 1; ctl_wdata <= v; end
      @(posedge clk_sys);
      seed_wr <= 0;
      ctl_wr <= 0;
   endtask
   task automatic run(input [7:0] s, input [7:0] c, input [15:0] e);
      wr(1, s);
      wr(0, c);
      if (c[3:2] != 2'h3) go <= 1;
      @(posedge clk_sys);
      go <= 0;
      while (stc[0] !== 1'b0 || ces !== 1'b0) @(negedge clk_sys);
      `CHK({csh, csl}, e)
      `CHK(stc[0], 1'b0)
   endtask
   task automatic give_verdict;
      if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin miscompares++; give_verdict; end
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      srst <= 0;
      @(negedge clk_sys);
      `CHK({stc, csh, csl}, 24'h000000)
      run(8'h5A, 8'hE7, 16'hF807);
      run(8'h00, 8'h17, 16'hF807);
      run(8'h00, 8'h03, 16'hFFFF);
      run(8'h00, 8'h0F, 16'hFFFF);
      rs = lfsr(rs);
      sd = rs[7:0] | 8'h01;
      ef = exp_fill(sd, 3'h0, 1'b1);
      run(sd, {rs[10:8], 5'h1F}, ef[15:0]);
      `CHK(fsd, ef[23:16])
      rs = lfsr(rs);
      ef = exp_fill(rs[7:0], rs[10:8], 1'b0);
      run(rs[7:0], {rs[10:8], 5'h0B}, ef[15:0]);
      `CHK(fsd, ef[23:16])
      wr(0, 8'h07);
      repeat (50) @(posedge clk_sys);
      wr(0, 8'h00);
      // Long enough for an unaborted fill to finish and load its sum
      repeat (8300) @(negedge clk_sys);
      `CHK(stc[0], 1'b0)
      `CHK({csh, csl}, ef[15:0])
      give_verdict;
   end
endmodule // mbst_ctrl_tb_top
